// ===== core/hls_sequencer.sv
// Head load, return-to-zero and unload sequencer with AHB-Lite registers
// Notes on behaviour
// - Refuse seek commands until first load completes
// - Load end raises seek end and ready
// - Load latch sets after power-on and speed
// - Heads loaded enables dibit search
// - Odd dibits end load, set reverse flag
// - No dibits in 350 ms: retract, fault
// - Fault switch clears fault, reloads
// - Tag 3 bus 6 starts return to zero
// - First reverse limit sets flag, resets integrator
// - Second reverse limit switches to load
// - Fine jammed off while load or retract
// - Even dibits clear reverse limit flag
// - Power-off retracts without limit detection
// - Heads unloaded clears retract, coil off
// - Seek end after every seek not cut short by unload
// - Success is on-cylinder without seek error
// - Seek error refuses seeks until return
// - On-cylinder waits 1.75 ms settle
// - Return command clears seek error
`timescale 1ns/1ns
module hls_sequencer
  import hls_pkg::*;
#(
  parameter logic [23:0] LOAD_TO_CYC = LOAD_TO_CYC_DEF,
  parameter logic [15:0] SETTLE_CYC = SETTLE_CYC_DEF
) (
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic ce,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic start_sw,
  input wire logic spindle_ok,
  input wire logic heads_loaded_sw,
  input wire logic pos_odd_dibit,
  input wire logic neg_even_dibit,
  input wire logic forward_limit_enable,
  input wire logic reverse_limit_enable,
  input wire logic on_cyl_sense,
  input wire logic fault_sw,
  input wire logic power_off,
  input wire logic seek_error_cause,
  input wire logic seek_cmd,
  input wire logic [3:0] tag,
  input wire logic [9:0] bus,
  output hls_servo_t servo,
  output hls_ctl_t ctl,
  output logic ready,
  output logic fault_ind
);
  // ==========================================================
  // State
  hls_state_t s_r;
  hls_state_t s_nxt;
  logic [NPIN-1:0] pins;
  logic [NPIN-1:0] rise;
  logic [NPIN-1:0] fall;
  logic rtz_tag;

  assign rtz_tag = (tag == 4'(TAG_CTRL)) && bus[BUS_RTZ];
  assign pins = {seek_cmd, seek_error_cause, power_off, fault_sw,
                 on_cyl_sense, reverse_limit_enable, forward_limit_enable,
                 neg_even_dibit, pos_odd_dibit, heads_loaded_sw,
                 spindle_ok, start_sw};

  // Tag and bus are qualified by the synchronised command strobe
  function automatic logic [31:0] rd_mux(input hls_state_t s,
                                         input logic [7:0] a);
    logic [31:0] v;
    v = 32'h0000_0000;
    case (a)
      REG_CTRL: v = {30'h0000_0000, s.ctrl};
      REG_STATUS: v = {20'h0_0000, s.loaded_ok, s.ready, s.fault_l,
                       s.seek_err_l, s.on_cyl, s.fine_l, s.rev_eot,
                       s.unload, s.rtz_l, s.load_l, s.busy,
                       s.ctl.seek_end};
      default: v = 32'h0000_0000;
    endcase
    return v;
  endfunction

  genvar gi;
  generate
    for (gi = 0; gi < NPIN; gi++) begin : g_edge
      assign rise[gi] = s_r.f[gi] && !s_r.f_d[gi];
      assign fall[gi] = !s_r.f[gi] && s_r.f_d[gi];
    end
  endgenerate

  // ==========================================================
  // Next state
  always_comb begin
    logic rtz_cmd;
    logic set_load;
    logic start_seek;
    logic addr_ph;
    logic unload_done;
    unload_done = s_r.rtz_l && s_r.unload && !s_r.f[P_LOADED];
    rtz_cmd = 1'b0;
    set_load = 1'b0;
    start_seek = 1'b0;
    addr_ph = 1'b0;
    s_nxt = s_r;
    // Two agreeing samples after the metastability stage
    s_nxt.s1 = pins;
    s_nxt.s2 = s_r.s1;
    s_nxt.s3 = s_r.s2;
    s_nxt.f_d = s_r.f;
    for (int i = 0; i < NPIN; i++) begin
      if (s_r.s2[i] == s_r.s3[i]) begin
        s_nxt.f[i] = s_r.s3[i];
      end
    end
    s_nxt.ctl.cmd_accept = 1'b0;
    s_nxt.ctl.cmd_refused = 1'b0;
    s_nxt.servo.integ_reset = 1'b0;

    // Controller commands; the tag pins ride with the command strobe
    if (rise[P_SEEK_CMD] && s_r.ctrl[CTRL_CMD_EN]) begin
      if (rtz_tag && !s_r.unload && !s_r.fault_l) begin
        rtz_cmd = 1'b1;
      end else if (!rtz_tag && s_r.loaded_ok && !s_r.seek_err_l
                   && !s_r.busy) begin
        s_nxt.ctl.cmd_accept = 1'b1;
      end else begin
        s_nxt.ctl.cmd_refused = 1'b1;
      end
    end

    // Load request with power-on, motion after spindle speed
    if (rise[P_START]) begin
      s_nxt.load_pend = 1'b1;
    end
    if (rise[P_FAULT_SW] && s_r.fault_l) begin
      s_nxt.fault_l = 1'b0;
      s_nxt.load_pend = 1'b1;
    end
    if (s_r.load_pend && s_r.f[P_SPIN_OK] && !s_r.rtz_l
        && !s_r.load_l) begin
      s_nxt.load_pend = 1'b0;
      set_load = 1'b1;
    end

    if (rtz_cmd) begin
      s_nxt.rtz_l = 1'b1;
      s_nxt.load_l = 1'b0;
      s_nxt.rev_cnt = 1'b0;
      s_nxt.seek_err_l = 1'b0;
      start_seek = 1'b1;
    end

    // Return to zero: two reverse limit events
    if (s_r.rtz_l && !s_r.unload && s_r.ctrl[CTRL_EOT_EN]
        && rise[P_REV_LIM]) begin
      if (!s_r.rev_cnt) begin
        s_nxt.rev_cnt = 1'b1;
        s_nxt.rev_eot = 1'b1;
        s_nxt.servo.integ_reset = 1'b1;
      end else begin
        s_nxt.rtz_l = 1'b0;
        set_load = 1'b1;
      end
    end

    if (set_load) begin
      s_nxt.load_l = 1'b1;
      s_nxt.to_cnt = 24'h00_0000;
      s_nxt.dibit_seen = 1'b0;
      start_seek = 1'b1;
    end

    // Load coarse phase
    if (s_r.load_l) begin
      if (s_r.servo.dibit_enable
          && (s_r.f[P_POS_ODD] || s_r.f[P_NEG_EVEN])) begin
        s_nxt.dibit_seen = 1'b1;
      end
      if (s_r.servo.dibit_enable && s_r.f[P_POS_ODD]
          && s_r.f[P_FWD_LIM]) begin
        s_nxt.load_l = 1'b0;
        s_nxt.rev_eot = 1'b1;
      end else if (!s_r.dibit_seen
                   && s_r.to_cnt == LOAD_TO_CYC - 24'h00_0001) begin
        // Retract fully; limit detection off so heads unload
        s_nxt.load_l = 1'b0;
        s_nxt.rtz_l = 1'b1;
        s_nxt.unload = 1'b1;
        s_nxt.fault_l = 1'b1;
      end else if (!s_r.dibit_seen) begin
        s_nxt.to_cnt = s_r.to_cnt + 24'h00_0001;
      end
    end

    // Even dibits near cylinder zero end the reverse zone
    if (s_r.rev_eot && s_r.f[P_NEG_EVEN] && !s_r.rtz_l
        && !s_r.load_l) begin
      s_nxt.rev_eot = 1'b0;
    end

    // Power-off retract
    if (rise[P_PWR_OFF]) begin
      s_nxt.rtz_l = 1'b1;
      s_nxt.unload = 1'b1;
      s_nxt.load_l = 1'b0;
      s_nxt.load_pend = 1'b0;
      s_nxt.loaded_ok = 1'b0;
    end
    if (unload_done) begin
      s_nxt.rtz_l = 1'b0;
      s_nxt.unload = 1'b0;
      s_nxt.rev_eot = 1'b0;
    end

    // Fine latch jammed while either coarse latch holds
    if (s_nxt.load_l || s_nxt.rtz_l) begin
      s_nxt.fine_l = 1'b0;
    end else if (s_r.rev_eot && !unload_done) begin
      s_nxt.fine_l = 1'b1;
    end

    // On-cylinder settle delay
    if (s_r.fine_l && s_r.f[P_ONCYL_SNS] && !s_nxt.load_l
        && !s_nxt.rtz_l) begin
      if (!s_r.on_cyl) begin
        if (s_r.st_cnt == SETTLE_CYC - 16'h0001) begin
          s_nxt.on_cyl = 1'b1;
        end else begin
          s_nxt.st_cnt = s_r.st_cnt + 16'h0001;
        end
      end
    end else begin
      s_nxt.st_cnt = 16'h0000;
      s_nxt.on_cyl = 1'b0;
    end

    // Seek error latch; a new cause beats a clear in the same cycle
    if (s_r.f[P_SEEK_ERR]) begin
      s_nxt.seek_err_l = 1'b1;
    end

    // Seek end on success or error
    if (start_seek) begin
      s_nxt.busy = 1'b1;
      s_nxt.ctl.seek_end = 1'b0;
      s_nxt.on_cyl = 1'b0;
      s_nxt.st_cnt = 16'h0000;
    end else if (s_r.busy && (s_r.on_cyl || s_r.seek_err_l)) begin
      s_nxt.busy = 1'b0;
      s_nxt.ctl.seek_end = 1'b1;
      if (s_r.on_cyl && !s_r.seek_err_l) begin
        s_nxt.loaded_ok = 1'b1;
      end
    end
    if (s_r.unload) begin
      s_nxt.busy = 1'b0;
    end

    s_nxt.ready = s_nxt.loaded_ok && !s_nxt.busy;
    s_nxt.ctl.on_cylinder = s_nxt.on_cyl;
    s_nxt.ctl.seek_error = s_nxt.seek_err_l;
    s_nxt.fault_ind = s_nxt.fault_l;
    s_nxt.servo.load_drive = s_nxt.load_l;
    s_nxt.servo.rtz_drive = s_nxt.rtz_l;
    s_nxt.servo.fine = s_nxt.fine_l;
    s_nxt.servo.dibit_enable = s_nxt.f[P_LOADED] && !s_nxt.unload;
    s_nxt.servo.coil_enable = s_nxt.load_l || s_nxt.rtz_l
                              || s_nxt.fine_l;

    // AHB-Lite slave, zero wait states
    s_nxt.dp_wr = 1'b0;
    addr_ph = hsel && hready && (htrans == HTRANS_NONSEQ);
    if (s_r.dp_wr) begin
      if (s_r.dp_addr == REG_CTRL) begin
        s_nxt.ctrl = hwdata[CTRL_EOT_EN:CTRL_CMD_EN];
        // Software fault reset mirrors the panel switch
        if (hwdata[CTRL_FAULT_CLR] && s_r.fault_l) begin
          s_nxt.fault_l = 1'b0;
          s_nxt.fault_ind = 1'b0;
          s_nxt.load_pend = 1'b1;
        end
      end
    end
    if (addr_ph) begin
      s_nxt.dp_wr = hwrite;
      s_nxt.dp_addr = haddr[7:0];
      s_nxt.rdata = rd_mux(s_r, haddr[7:0]);
    end
  end

  // ==========================================================
  // Registers
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      s_r <= '0;
      s_r.ctrl <= CTRL_RESET;
    end else if (ce) begin
      s_r <= s_nxt;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = s_r.rdata;
  assign servo = s_r.servo;
  assign ctl = s_r.ctl;
  assign ready = s_r.ready;
  assign fault_ind = s_r.fault_ind;

  // ==========================================================
  // Checks
  default clocking cb @(posedge hclk); endclocking
  default disable iff (!hresetn || !ce);

  a_fine_jammed: assert property (
    (s_r.load_l || s_r.rtz_l) |-> !s_r.fine_l)
    else $error("fine latch set during load or retract");
  a_load_timeout: assert property (
    (s_r.load_l && !s_r.dibit_seen && !s_r.servo.dibit_enable
     && s_r.to_cnt == LOAD_TO_CYC - 24'h00_0001 && !rise[P_PWR_OFF])
    |=> (s_r.fault_l && s_r.rtz_l && !s_r.load_l))
    else $error("load timeout did not retract with fault");
  a_load_exit: assert property (
    (s_r.load_l && s_r.servo.dibit_enable && s_r.f[P_POS_ODD]
     && s_r.f[P_FWD_LIM] && !rise[P_PWR_OFF])
    |=> (!s_r.load_l && s_r.rev_eot) ##1 s_r.fine_l)
    else $error("odd dibits did not hand over to fine");
  a_unload_end: assert property (
    (s_r.rtz_l && s_r.unload && !s_r.f[P_LOADED] && !rise[P_PWR_OFF])
    |=> (!s_r.rtz_l && !s_r.servo.coil_enable))
    else $error("unload did not release retract latch");
  a_settle_time: assert property (
    $rose(s_r.on_cyl) |-> $past(s_r.st_cnt) == SETTLE_CYC - 16'h0001)
    else $error("on cylinder set before settle delay");
  a_seek_end: assert property (
    (s_r.busy && (s_r.on_cyl || s_r.seek_err_l) && !rise[P_SEEK_CMD]
     && !rise[P_REV_LIM] && !rise[P_PWR_OFF]
     && !(s_r.load_pend && s_r.f[P_SPIN_OK]))
    |=> ctl.seek_end)
    else $error("seek end missing after seek");
  a_refuse_unloaded: assert property (
    (!s_r.loaded_ok && rise[P_SEEK_CMD] && !rtz_tag)
    |=> !ctl.cmd_accept ##1 !ctl.cmd_accept)
    else $error("command accepted before load");
  a_rtz_clears: assert property (
    (rise[P_SEEK_CMD] && rtz_tag && s_r.ctrl[CTRL_CMD_EN]
     && !s_r.unload && !s_r.fault_l && !s_r.f[P_SEEK_ERR])
    |=> (!s_r.seek_err_l && s_r.rtz_l))
    else $error("return command did not clear seek error");
  a_rev_second: assert property (
    (s_r.rtz_l && s_r.rev_cnt && !s_r.unload && s_r.ctrl[CTRL_EOT_EN]
     && rise[P_REV_LIM] && !rise[P_PWR_OFF] && !rise[P_SEEK_CMD])
    |=> (s_r.load_l && !s_r.rtz_l))
    else $error("second reverse limit did not start load");

  c_load_done: cover property ($rose(s_r.loaded_ok));
  c_timeout: cover property ($rose(s_r.fault_l));
  c_rtz_full: cover property (s_r.rtz_l && s_r.rev_cnt ##1 s_r.load_l);
  c_unload: cover property ($fell(s_r.unload));
endmodule // hls_sequencer

// ===== include/hls_pkg.sv
// Package: constants and carrier types for the head load sequencer
package hls_pkg;
  // ==========================================================
  // Timing
  localparam int unsigned CLK_NS = 40;
  localparam int unsigned LOAD_TIMEOUT_NS = 350_000_000;
  localparam int unsigned SETTLE_NS = 1_750_000;
  localparam logic [23:0] LOAD_TO_CYC_DEF =
    24'(LOAD_TIMEOUT_NS / CLK_NS);
  localparam logic [15:0] SETTLE_CYC_DEF =
    16'((SETTLE_NS + CLK_NS - 1) / CLK_NS);
  // ==========================================================
  // Register map (byte addresses, AHB-Lite word registers)
  localparam logic [7:0] REG_CTRL = 8'h00;
  localparam logic [7:0] REG_STATUS = 8'h04;
  localparam int CTRL_CMD_EN = 0;
  localparam int CTRL_EOT_EN = 1;
  localparam int CTRL_FAULT_CLR = 2;
  localparam logic [1:0] CTRL_RESET = 2'h3;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // ==========================================================
  // Pin inputs, synchronised; tag and bus are decoded raw
  localparam int NPIN = 12;
  localparam int P_START = 0;
  localparam int P_SPIN_OK = 1;
  localparam int P_LOADED = 2;
  localparam int P_POS_ODD = 3;
  localparam int P_NEG_EVEN = 4;
  localparam int P_FWD_LIM = 5;
  localparam int P_REV_LIM = 6;
  localparam int P_ONCYL_SNS = 7;
  localparam int P_FAULT_SW = 8;
  localparam int P_PWR_OFF = 9;
  localparam int P_SEEK_ERR = 10;
  localparam int P_SEEK_CMD = 11;
  localparam int TAG_CTRL = 3;
  localparam int BUS_RTZ = 6;
  // ==========================================================
  // Types
  typedef struct packed {
    logic load_drive;
    logic rtz_drive;
    logic fine;
    logic dibit_enable;
    logic integ_reset;
    logic coil_enable;
  } hls_servo_t;
  typedef struct packed {
    logic seek_end;
    logic on_cylinder;
    logic seek_error;
    logic cmd_accept;
    logic cmd_refused;
  } hls_ctl_t;
  typedef struct packed {
    logic [NPIN-1:0] s1;
    logic [NPIN-1:0] s2;
    logic [NPIN-1:0] s3;
    logic [NPIN-1:0] f;
    logic [NPIN-1:0] f_d;
    logic load_pend;
    logic load_l;
    logic rtz_l;
    logic unload;
    logic rev_eot;
    logic fine_l;
    logic fault_l;
    logic seek_err_l;
    logic on_cyl;
    logic loaded_ok;
    logic busy;
    logic dibit_seen;
    logic rev_cnt;
    logic [23:0] to_cnt;
    logic [15:0] st_cnt;
    hls_servo_t servo;
    hls_ctl_t ctl;
    logic ready;
    logic fault_ind;
    logic [1:0] ctrl;
    logic dp_wr;
    logic [7:0] dp_addr;
    logic [31:0] rdata;
  } hls_state_t;
endpackage

// ===== tb/hls_ctl_model.sv
// Disk controller model: issues tag/bus commands, judges seek outcome
`timescale 1ns/1ns
module hls_ctl_model
  import hls_pkg::*;
(
  input wire logic hclk,
  input wire logic hresetn,
  input wire logic go,
  input wire logic return_to_zero_latch,
  input hls_ctl_t ctl,
  output logic seek_cmd,
  output logic [3:0] tag,
  output logic [9:0] bus,
  output logic done_ok
);
  logic [3:0] cnt;
  logic end_d;
  // ==========================================================
  // Command issue and outcome sampling
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cnt <= 4'h0;
      seek_cmd <= 1'b0;
      tag <= 4'h0;
      bus <= 10'h000;
      done_ok <= 1'b0;
      end_d <= 1'b0;
    end else begin
      end_d <= ctl.seek_end;
      if (ctl.seek_end && !end_d) begin
        done_ok <= ctl.on_cylinder && !ctl.seek_error;
      end
      if (cnt == 4'h0 && go) begin
        cnt <= 4'h1;
        tag <= return_to_zero_latch ? 4'(TAG_CTRL) : 4'h1;
        bus <= return_to_zero_latch ? 10'h040 : 10'h001;
      end else if (cnt != 4'h0) begin
        cnt <= cnt + 4'h1;
        seek_cmd <= (cnt < 4'h7);
        // Tag and bus stay put well past the strobe, then go stale
        if (cnt == 4'hc) begin
          cnt <= 4'h0;
          tag <= ~tag;
          bus <= ~bus;
        end
      end
    end
  end
endmodule // hls_ctl_model

// ===== tb/testbench.sv
// Bench: load, return-to-zero, unload and timeout through the pins
`timescale 1ns/1ns
module testbench
  import hls_pkg::*;
();
  localparam int B_COIL = 0, B_INT = 1, B_DIB = 2, B_FINE = 3, B_RTZ = 4;
  localparam int B_LOAD = 5, B_REF = 6, B_SERR = 8, B_ONC = 9, B_SEND = 10;
  localparam int B_RDY = 11, B_FLT = 12;
  logic hclk = 1'b0;
  logic hresetn, hsel, hwrite, hreadyout, seek_cmd, go, return_to_zero_latch, done_ok;
  logic start_sw, spindle_ok, heads_loaded_sw, pos_odd_dibit;
  logic neg_even_dibit, forward_limit_enable, reverse_limit_enable;
  logic on_cyl_sense, fault_sw, power_off, seek_error_cause;
  logic [31:0] haddr, hwdata, hrdata, rd;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [3:0] tag;
  logic [9:0] bus;
  logic [12:0] obs;
  hls_servo_t servo;
  hls_ctl_t ctl;
  logic ready, fault_ind, hresp;
  int error_cnt = 0;
  int tests_run = 0;
  int cyc_cnt = 0;
  int n;
  assign obs = {fault_ind, ready, ctl, servo};
  always #20 hclk = ~hclk;
  // Short counts keep the run small
  hls_sequencer #(.LOAD_TO_CYC(24'h00_00C8), .SETTLE_CYC(16'h0014))
    hls_sequencer_i (.hclk, .hresetn, .ce(1'b1), .hsel, .haddr, .htrans,
    .hwrite, .hsize, .hwdata, .hready(hreadyout), .hreadyout, .hresp,
    .hrdata, .start_sw, .spindle_ok, .heads_loaded_sw, .pos_odd_dibit,
    .neg_even_dibit, .forward_limit_enable, .reverse_limit_enable,
    .on_cyl_sense, .fault_sw, .power_off, .seek_error_cause, .seek_cmd,
    .tag, .bus, .servo, .ctl, .ready, .fault_ind);
  hls_ctl_model hls_ctl_model_i (.hclk, .hresetn, .go, .return_to_zero_latch, .ctl,
    .seek_cmd, .tag, .bus, .done_ok);
  // ==========================================================
  // Helpers
  task automatic report_and_stop();
    if (error_cnt == 0 && tests_run > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      error_cnt++;
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
    end
  endtask
  // Leaves the elapsed cycle count in n for timing checks
  task automatic wait_bit(input int idx, input logic v, input int lim);
    n = 0;
    do begin
      @(posedge hclk);
      #1;
      n++;
    end while (obs[idx] !== v && n < lim);
    chk32(32'(obs[idx]), 32'(v));
  endtask
  task automatic hold(input int c);
    repeat (c) @(posedge hclk);
  endtask
  task automatic ahb(input logic w, input logic [31:0] a,
                     input logic [31:0] d);
    @(posedge hclk);
    hsel <= 1'b1;
    htrans <= HTRANS_NONSEQ;
    haddr <= a;
    hwrite <= w;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge hclk); while (hreadyout !== 1'b1);
    rd = hrdata;
  endtask
  // Gap first, so the model is idle before a new command
  task automatic cmd(input logic r);
    hold(14);
    go <= 1'b1;
    return_to_zero_latch <= r;
    @(posedge hclk);
    go <= 1'b0;
  endtask
  task automatic do_reset();
    @(posedge hclk);
    hresetn <= 1'b0;
    {start_sw, spindle_ok, heads_loaded_sw, pos_odd_dibit} <= 4'h0;
    {neg_even_dibit, forward_limit_enable, reverse_limit_enable} <= 3'h0;
    {on_cyl_sense, fault_sw, power_off, seek_error_cause} <= 4'h0;
    {go, return_to_zero_latch} <= 2'h0;
    hold(12);
    hresetn <= 1'b1;
  endtask
  task automatic do_load();
    @(posedge hclk);
    start_sw <= 1'b1;
    hold(10);
    chk32(32'(servo.load_drive), 32'h0);
    spindle_ok <= 1'b1;
    wait_bit(B_LOAD, 1'b1, 20);
    chk32(32'(servo.fine), 32'h0);
    @(posedge hclk);
    heads_loaded_sw <= 1'b1;
    wait_bit(B_DIB, 1'b1, 20);
    @(posedge hclk);
    pos_odd_dibit <= 1'b1;
    forward_limit_enable <= 1'b1;
    wait_bit(B_LOAD, 1'b0, 20);
    wait_bit(B_FINE, 1'b1, 10);
    @(posedge hclk);
    pos_odd_dibit <= 1'b0;
    on_cyl_sense <= 1'b1;
    wait_bit(B_ONC, 1'b1, 40);
    chk32(32'(n >= 20), 32'h1);
    wait_bit(B_SEND, 1'b1, 5);
    wait_bit(B_RDY, 1'b1, 5);
  endtask
  always @(posedge hclk) begin
    cyc_cnt++;
    if (cyc_cnt == 6000) begin
      error_cnt++;
      report_and_stop();
    end
  end
  // ==========================================================
  // Main sequence
  initial begin
    {hresetn, hsel, hwrite, htrans, hsize} <= 8'h02;
    {haddr, hwdata} <= 64'h0;
    do_reset();
    ahb(1'b0, 32'(REG_CTRL), 32'h0);
    chk32(rd, 32'(CTRL_RESET));
    chk32(32'(hresp), 32'h0);
    ahb(1'b0, 32'(REG_STATUS), 32'h0);
    chk32(rd, 32'h0000_0000);
    ahb(1'b1, 32'h0000_0010, 32'hFFFF_FFFF);
    ahb(1'b0, 32'h0000_0010, 32'h0);
    chk32(rd, 32'h0000_0000);
    cmd(1'b0);
    wait_bit(B_REF, 1'b1, 30);
    do_load();
    chk32(32'(done_ok), 32'h1);
    @(posedge hclk);
    seek_error_cause <= 1'b1;
    wait_bit(B_SERR, 1'b1, 20);
    @(posedge hclk);
    seek_error_cause <= 1'b0;
    cmd(1'b0);
    wait_bit(B_REF, 1'b1, 30);
    cmd(1'b1);
    wait_bit(B_RTZ, 1'b1, 30);
    wait_bit(B_SERR, 1'b0, 5);
    chk32(32'(servo.fine), 32'h0);
    @(posedge hclk);
    reverse_limit_enable <= 1'b1;
    wait_bit(B_INT, 1'b1, 15);
    @(posedge hclk);
    reverse_limit_enable <= 1'b0;
    ahb(1'b0, 32'(REG_STATUS), 32'h0);
    chk32(rd & 32'h0000_002C, 32'h0000_0028);
    hold(8);
    reverse_limit_enable <= 1'b1;
    wait_bit(B_LOAD, 1'b1, 15);
    chk32(32'(servo.rtz_drive), 32'h0);
    @(posedge hclk);
    reverse_limit_enable <= 1'b0;
    pos_odd_dibit <= 1'b1;
    wait_bit(B_LOAD, 1'b0, 20);
    @(posedge hclk);
    pos_odd_dibit <= 1'b0;
    neg_even_dibit <= 1'b1;
    hold(10);
    ahb(1'b0, 32'(REG_STATUS), 32'h0);
    chk32(rd & 32'h0000_0020, 32'h0000_0000);
    do_reset();
    do_load();
    @(posedge hclk);
    power_off <= 1'b1;
    wait_bit(B_RTZ, 1'b1, 20);
    @(posedge hclk);
    reverse_limit_enable <= 1'b1;
    hold(10);
    chk32(32'({servo.load_drive, servo.rtz_drive}), 32'h1);
    heads_loaded_sw <= 1'b0;
    wait_bit(B_RTZ, 1'b0, 20);
    wait_bit(B_COIL, 1'b0, 5);
    do_reset();
    @(posedge hclk);
    {start_sw, spindle_ok} <= 2'h3;
    wait_bit(B_LOAD, 1'b1, 20);
    wait_bit(B_FLT, 1'b1, 260);
    chk32(32'(n >= 195), 32'h1);
    chk32(32'(servo.rtz_drive), 32'h1);
    @(posedge hclk);
    fault_sw <= 1'b1;
    wait_bit(B_FLT, 1'b0, 20);
    wait_bit(B_LOAD, 1'b1, 20);
    @(posedge hclk);
    fault_sw <= 1'b0;
    wait_bit(B_FLT, 1'b1, 260);
    chk32(32'(n >= 190), 32'h1);
    report_and_stop();
  end
endmodule // testbench
